// [hdl/snf_device.sv]
// Purpose: Feature register bank and write guard of a serial NAND device
// Assumes: Link pins sampled by ref_clk; rst_n stands for a power cycle
// Notes:   Array, OTP and ECC engines are outside; this end exports controls
// Overview of operation
// - Modes 0 and 3 supported only
// - Sample rising edge, launch on falling
// - Host parks clock while deselected
// - Host toggles clock only after select; this host may move sck with the select edge on a mode change
// - 0Fh reads, 1Fh writes, address byte follows
// - Features survive reset command
// - Lock control fully volatile, writable
// - Host sets guard bits before freeze
// - All guards off: pin is data line
// - Guard high only: pin gates lock writes
// - Guard low only: lock frozen till power-off
// - Both guards: freeze allowed, then locked
// - Pin guard and pin low: read-only
// - Pin guard, pin high: lock changeable, no x4
// - Power cycle clears guard bits
// - Reset busy time bounded by activity
// - First reset after power-up within 1 ms
// - Host limits clock for dual/quad reads
// - Locked region ignores program and erase
// - Status readable while busy
// - OTP and ECC enables volatile, writable
`timescale 1ns/100ps
module snf_device import snf_pkg::*; #(
  parameter int FIRST_RST_CYC = RST_FIRST_CYC,
  parameter int IDLE_RST_CYC  = RST_IDLE_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  snf_link_if.device      link,
  output logic            ecc_enable,
  output logic            otp_access,
  output logic            quad_allowed,
  output logic            read_only,
  output logic [4:0]      region_lock,
  output logic            busy
);
  typedef enum logic [1:0] {
    DS_OP   = 2'b00,
    DS_ADDR = 2'b01,
    DS_DATA = 2'b10,
    DS_DONE = 2'b11
  } snf_dev_state_type;

  snf_dev_state_type state;
  logic [1:0]  cs_s;
  logic [1:0]  sck_s;
  logic [1:0]  mosi_s;
  logic [1:0]  guard_s;
  logic        sck_d;
  logic        cs_d;
  logic [6:0]  in_sr;
  logic [2:0]  bit_cnt;
  logic [7:0]  opcode;
  logic [7:0]  addr;
  logic [7:0]  out_sr;
  logic [7:0]  lock_control;
  logic [7:0]  configuration;
  logic [7:0]  output_drive_strength;
  logic        write_enable_latch;
  logic [15:0] busy_cnt;
  logic        first_reset_done;
  logic        active;
  logic        rise;
  logic        fall;
  logic        byte_done;
  logic [7:0]  next_byte;
  logic        op_busy;
  logic        pin_block;
  logic        write_req;

  function automatic logic lock_writable(input logic [7:0] lk, input logic frz, input logic pin_hi);
    logic p0;
    logic p1;
    p0 = lk[LK_GUARD_HIGH];
    p1 = lk[LK_GUARD_LOW];
    if (frz)
      return 1'b0;
    if (p1 && !p0)
      return 1'b0;
    if (p1 && p0)
      return 1'b1;
    if (p0 && !lk[LK_PIN_GUARD])
      return pin_hi;
    return 1'b1;
  endfunction

  function automatic logic [7:0] feature_read(input logic [7:0] fa, input logic [7:0] lk,
                                              input logic [7:0] cf, input logic [7:0] dr,
                                              input logic wl, input logic bz);
    logic [7:0] st;
    st = 8'h00;
    st[ST_WEL] = wl;
    st[ST_OIP] = bz;
    if (fa == FA_LOCK)
      return lk;
    else if (fa == FA_CONFIG)
      return cf & CONFIG_MASK;
    else if (fa == FA_STATUS)
      return st;
    else if (fa == FA_DRIVE)
      return dr & DRIVE_MASK;
    return 8'h00;
  endfunction

  // Two-flop synchronisers; the clock and the select get a third stage for edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s    <= 2'h3;
      sck_s   <= 2'h0;
      mosi_s  <= 2'h0;
      guard_s <= 2'h3;
      sck_d   <= 1'b0;
      cs_d    <= 1'b1;
    end else begin
      cs_s    <= {cs_s[0], link.cs_n};
      sck_s   <= {sck_s[0], link.sck};
      mosi_s  <= {mosi_s[0], link.mosi};
      guard_s <= {guard_s[0], link.guard_n};
      sck_d   <= sck_s[1];
      cs_d    <= cs_s[1];
    end
  end

  // Edge roles are the same in modes 0 and 3
  // A mode change moves sck with the select edge; skip that first cycle
  assign active    = !cs_s[1] && !cs_d;
  assign rise      = active && sck_s[1] && !sck_d;
  assign fall      = active && !sck_s[1] && sck_d;
  assign next_byte = {in_sr, mosi_s[1]};
  assign byte_done = rise && (bit_cnt == 3'h7);
  assign op_busy   = (busy_cnt != 16'h0000);
  assign pin_block = lock_control[LK_PIN_GUARD] && !guard_s[1];
  assign write_req = byte_done && (state == DS_DATA) && (opcode == OP_SET_FEATURE) && !op_busy;

  // Framing; deselect aborts any partial byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= DS_OP;
      in_sr   <= 7'h00;
      bit_cnt <= 3'h0;
      opcode  <= 8'h00;
      addr    <= 8'h00;
    end else if (!active) begin
      state   <= DS_OP;
      bit_cnt <= 3'h0;
    end else if (rise) begin
      in_sr   <= next_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        case (state)
          DS_OP: begin
            opcode <= next_byte;
            if (next_byte == OP_GET_FEATURE || next_byte == OP_SET_FEATURE)
              state <= DS_ADDR;
            else
              state <= DS_DONE;
          end
          DS_ADDR: begin
            addr  <= next_byte;
            state <= DS_DATA;
          end
          default: state <= DS_DONE;
        endcase
      end
    end
  end

  // Read data launched from falling edges, first bit after address byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sr       <= 8'h00;
      link.miso    <= 1'b0;
      link.miso_oe <= 1'b0;
    end else if (!active) begin
      out_sr       <= 8'h00;
      link.miso    <= 1'b0;
      link.miso_oe <= 1'b0;
    end else if (byte_done && state == DS_ADDR && opcode == OP_GET_FEATURE) begin
      out_sr <= feature_read(next_byte, lock_control, configuration, output_drive_strength,
                             write_enable_latch, op_busy);
    end else if (fall && state != DS_OP && state != DS_ADDR && opcode == OP_GET_FEATURE) begin
      link.miso    <= out_sr[7];
      link.miso_oe <= 1'b1;
      out_sr       <= {out_sr[6:0], 1'b0};
    end
  end

  // Feature registers; only rst_n (power cycle) restores them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_control          <= LOCK_RESET;
      configuration         <= CONFIG_RESET;
      output_drive_strength <= DRIVE_RESET;
    end else if (write_req && !pin_block) begin
      if (addr == FA_LOCK) begin
        if (lock_writable(lock_control, configuration[CF_FREEZE], guard_s[1]))
          lock_control <= next_byte;
      end else if (addr == FA_CONFIG) begin
        configuration <= next_byte & CONFIG_MASK;
        // Freeze only sets with both guard bits, never clears
        configuration[CF_FREEZE] <= configuration[CF_FREEZE] |
          (next_byte[CF_FREEZE] & lock_control[LK_GUARD_HIGH] & lock_control[LK_GUARD_LOW]);
      end else if (addr == FA_DRIVE) begin
        output_drive_strength <= next_byte & DRIVE_MASK;
      end
    end
  end

  // Reset command and write-enable latch; features are untouched
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt           <= 16'h0000;
      first_reset_done   <= 1'b0;
      write_enable_latch <= 1'b0;
    end else if (byte_done && state == DS_OP && next_byte == OP_RESET) begin
      // No array activity here, so only idle and power-up bounds apply
      busy_cnt           <= first_reset_done ? 16'(IDLE_RST_CYC) : 16'(FIRST_RST_CYC);
      first_reset_done   <= 1'b1;
      write_enable_latch <= 1'b0;
    end else begin
      if (op_busy)
        busy_cnt <= busy_cnt - 16'h0001;
      if (byte_done && state == DS_OP && !op_busy && next_byte == OP_WRITE_ENABLE)
        write_enable_latch <= 1'b1;
      else if (byte_done && state == DS_OP && !op_busy && next_byte == OP_WRITE_DISABLE)
        write_enable_latch <= 1'b0;
    end
  end

  // Registered controls toward array, OTP and pin logic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ecc_enable   <= 1'b0;
      otp_access   <= 1'b0;
      quad_allowed <= 1'b0;
      read_only    <= 1'b0;
      region_lock  <= 5'h00;
      busy         <= 1'b0;
    end else begin
      ecc_enable   <= configuration[CF_ECC_ENABLE];
      otp_access   <= configuration[CF_OTP_ENABLE];
      quad_allowed <= !lock_control[LK_PIN_GUARD];
      read_only    <= pin_block;
      // Array side drops program/erase inside this range
      region_lock  <= {lock_control[LK_BLOCK_MSB:LK_BLOCK_LSB], lock_control[LK_FROM_BOTTOM]};
      busy         <= op_busy;
    end
  end
endmodule

// [hdl/snf_host.sv]
// Purpose: Host controller issuing feature commands over the serial link
// Assumes: Classic Wishbone slave for software; link clock from a divider
// Notes:   One command per go; single-byte opcodes send only the opcode
`timescale 1ns/100ps
module snf_host import snf_pkg::*; #(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  snf_link_if.host         link
);
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_SETUP = 3'b001,
    HS_LOW   = 3'b010,
    HS_HIGH  = 3'b011,
    HS_TAIL  = 3'b100,
    HS_GAP   = 3'b101
  } snf_host_state_type;

  snf_host_state_type state;
  logic [7:0]  cmd_op;
  logic [7:0]  cmd_addr;
  logic [7:0]  cmd_wdata;
  logic        mode3;
  logic [1:0]  miso_s;
  logic [7:0]  rx;
  logic [23:0] tx_sr;
  logic [4:0]  bits_left;
  logic [7:0]  div_cnt;
  logic        tick;
  logic        req;
  logic        go;
  logic        idle_level;
  logic [7:0]  next_cmd_op;
  logic [7:0]  next_cmd_addr;
  logic [7:0]  next_cmd_wdata;

  // Go must frame this cycle's bytes, not the copies still being stored
  assign next_cmd_op    = wb_sel_i[0] ? wb_dat_i[7:0] : cmd_op;
  assign next_cmd_addr  = wb_sel_i[1] ? wb_dat_i[15:8] : cmd_addr;
  assign next_cmd_wdata = wb_sel_i[2] ? wb_dat_i[23:16] : cmd_wdata;
  assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign go   = req && wb_we_i && wb_adr_i == HOST_CMD_OFS && wb_sel_i[3] && wb_dat_i[HC_GO]
                && state == HS_IDLE;
  // Link clock stays far below the fast dual/quad read limit
  assign tick = (div_cnt == 8'(HALF_CYC - 1));
  // Idle level per mode as the parking rule gives it
  assign idle_level = !mode3;

  // Wishbone slave: ack one cycle after the request, dropped next cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
      cmd_op       <= 8'h00;
      cmd_addr     <= 8'h00;
      cmd_wdata    <= 8'h00;
      mode3        <= 1'b0;
      link.guard_n <= 1'b1;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && wb_we_i && wb_adr_i == HOST_CMD_OFS && state == HS_IDLE) begin
        if (wb_sel_i[0])
          cmd_op <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          cmd_addr <= wb_dat_i[15:8];
        if (wb_sel_i[2])
          cmd_wdata <= wb_dat_i[23:16];
        if (wb_sel_i[3]) begin
          mode3        <= wb_dat_i[HC_MODE3];
          link.guard_n <= wb_dat_i[HC_GUARD];
        end
      end else if (req && !wb_we_i && wb_adr_i == HOST_CMD_OFS) begin
        wb_dat_o <= {5'h00, link.guard_n, 1'b0, mode3, cmd_wdata, cmd_addr, cmd_op};
      end else if (req && !wb_we_i && wb_adr_i == HOST_STAT_OFS) begin
        wb_dat_o <= {16'h0000, rx, 7'h00, state != HS_IDLE};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      miso_s <= 2'h0;
    else
      miso_s <= {miso_s[0], link.miso};
  end

  // Half-period divider, restarted on each state change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      div_cnt <= 8'h00;
    else if (state == HS_IDLE || tick)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // Frame sequencer: select, then clock, bits change while clock is low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= HS_IDLE;
      link.cs_n <= 1'b1;
      link.sck  <= 1'b1;
      link.mosi <= 1'b0;
      tx_sr     <= 24'h000000;
      bits_left <= 5'h00;
      rx        <= 8'h00;
    end else begin
      case (state)
        HS_IDLE: begin
          link.sck <= idle_level;
          if (go) begin
            state     <= HS_SETUP;
            link.cs_n <= 1'b0;
            link.sck  <= !wb_dat_i[HC_MODE3];
            tx_sr     <= {next_cmd_op, next_cmd_addr, next_cmd_wdata};
            bits_left <= (next_cmd_op == OP_GET_FEATURE || next_cmd_op == OP_SET_FEATURE) ?
                         5'h18 : 5'h08;
          end
        end
        HS_SETUP: if (tick) begin
          state     <= HS_LOW;
          link.sck  <= 1'b0;
          link.mosi <= tx_sr[23];
        end
        HS_LOW: if (tick) begin
          state    <= HS_HIGH;
          link.sck <= 1'b1;
        end
        HS_HIGH: if (tick) begin
          rx        <= {rx[6:0], miso_s[1]};
          tx_sr     <= {tx_sr[22:0], 1'b0};
          bits_left <= bits_left - 5'h01;
          if (bits_left == 5'h01) begin
            state    <= HS_TAIL;
            link.sck <= idle_level;
          end else begin
            state     <= HS_LOW;
            link.sck  <= 1'b0;
            link.mosi <= tx_sr[22];
          end
        end
        HS_TAIL: if (tick) begin
          state     <= HS_GAP;
          link.cs_n <= 1'b1;
        end
        HS_GAP: if (tick)
          state <= HS_IDLE;
        default: state <= HS_IDLE;
      endcase
    end
  end
endmodule

// [hdl/snf_link_if.sv]
// Purpose: Serial link between host controller and feature device
// Assumes: Single-bit data, guard pin driven by the host
// Notes:   Output enable of the device data line is high while driven
`timescale 1ns/100ps
interface snf_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic guard_n;
  modport device (input cs_n, input sck, input mosi, input guard_n, output miso, output miso_oe);
  modport host   (output cs_n, output sck, output mosi, output guard_n, input miso, input miso_oe);
endinterface

// [hdl/snf_pkg.sv]
// Purpose: Shared constants for the serial NAND feature/protection link
// Assumes: 25 MHz ref_clk on both ends
// Notes:   Feature addresses, field positions and reset values
package snf_pkg;
  // Opcodes
  localparam logic [7:0] OP_GET_FEATURE   = 8'h0F;
  localparam logic [7:0] OP_SET_FEATURE   = 8'h1F;
  localparam logic [7:0] OP_RESET         = 8'hFF;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  // Feature addresses
  localparam logic [7:0] FA_LOCK          = 8'hA0;
  localparam logic [7:0] FA_CONFIG        = 8'hB0;
  localparam logic [7:0] FA_STATUS        = 8'hC0;
  localparam logic [7:0] FA_DRIVE         = 8'hD0;
  // Lock control fields
  localparam int LK_GUARD_HIGH  = 7;
  localparam int LK_BLOCK_MSB   = 6;
  localparam int LK_BLOCK_LSB   = 3;
  localparam int LK_FROM_BOTTOM = 2;
  localparam int LK_PIN_GUARD   = 1;
  localparam int LK_GUARD_LOW   = 0;
  // Configuration fields
  localparam int CF_OTP_PROTECT = 7;
  localparam int CF_OTP_ENABLE  = 6;
  localparam int CF_FREEZE      = 5;
  localparam int CF_ECC_ENABLE  = 4;
  // Status fields
  localparam int ST_WEL = 1;
  localparam int ST_OIP = 0;
  // Writable masks and power-on values
  localparam logic [7:0] CONFIG_MASK  = 8'hF0;
  localparam logic [7:0] DRIVE_MASK   = 8'h60;
  localparam logic [7:0] LOCK_RESET   = 8'h7C;
  localparam logic [7:0] CONFIG_RESET = 8'h10;
  localparam logic [7:0] DRIVE_RESET  = 8'h00;
  // Timing
  localparam int CLK_MHZ        = 25;
  localparam int T_RST_IDLE_US  = 5;
  localparam int T_RST_FIRST_US = 1000;
  localparam int RST_IDLE_CYC   = T_RST_IDLE_US * CLK_MHZ;
  localparam int RST_FIRST_CYC  = T_RST_FIRST_US * CLK_MHZ;
  localparam int LINK_HALF_CYC  = 4;
  // Host register map
  localparam logic [7:0] HOST_CMD_OFS  = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam int HC_MODE3 = 24;
  localparam int HC_GO    = 25;
  localparam int HC_GUARD = 26;
endpackage

// [test/snf_link_props.sv]
// Purpose: Wire checks on the link between host and device
// Assumes: Host half period left at its default of 4 ref_clk cycles
// Notes:   Takes the interface signals as plain inputs
`timescale 1ns/100ps
module snf_link_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic guard_n
);
  logic       sck_q;
  logic       cs_q;
  logic [5:0] rise_cnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b1;
      cs_q  <= 1'b1;
    end else begin
      sck_q <= sck;
      cs_q  <= cs_n;
    end
  end

  // Select edge itself not counted: a start level may move sck there
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      rise_cnt <= 6'h00;
    else if (cs_n)
      rise_cnt <= 6'h00;
    else if (sck && !sck_q && !cs_q)
      rise_cnt <= rise_cnt + 6'h01;
  end

  property p_sck_parked;
    cs_n && $past(cs_n) |-> $stable(sck);
  endproperty
  a_sck_parked: assert property (p_sck_parked) else $error("sck moved while deselected");

  property p_high_half;
    $rose(sck) && !cs_n |=> $stable(sck) [*3];
  endproperty
  a_high_half: assert property (p_high_half) else $error("sck high half too short");

  property p_low_half;
    $fell(sck) && !cs_n |=> $stable(sck) [*3];
  endproperty
  a_low_half: assert property (p_low_half) else $error("sck low half too short");

  property p_mosi_in_low;
    !cs_n && !$past(cs_n) && $changed(mosi) |-> !sck;
  endproperty
  a_mosi_in_low: assert property (p_mosi_in_low) else $error("mosi changed with sck high");

  property p_miso_launch;
    !cs_n && miso_oe && $past(miso_oe) && $changed(miso) |-> !sck && !sck_q;
  endproperty
  a_miso_launch: assert property (p_miso_launch) else $error("miso changed outside low phase");

  property p_oe_in_frame;
    $rose(miso_oe) |-> !cs_n && !cs_q;
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame) else $error("miso driven while deselected");

  property p_oe_release;
    $rose(cs_n) |-> ##[1:6] !miso_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("miso not released after deselect");

  property p_whole_bytes;
    $rose(cs_n) |-> rise_cnt[2:0] == 3'h0;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes) else $error("frame not a whole number of bytes");

  c_read_data: cover property ($rose(miso_oe));
  c_frame_end: cover property ($rose(cs_n));
  c_guard_frame: cover property (!guard_n && $fell(cs_n));
endmodule

// [test/test_spi_nand_feature_protection.sv]
// Purpose: Host and device joined, driven through the host register bus
// Assumes: Host link half period left at its default
// Notes:   First-reset busy count shortened so runs stay short; idle reset count lengthened
`timescale 1ns/100ps
module test_spi_nand_feature_protection import snf_pkg::*;;
  localparam int FIRST_N = 900;
  localparam int IDLE_N  = 300;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        ecc;
  logic        otp;
  logic        quad;
  logic        ro;
  logic [4:0]  region;
  logic        busy;
  logic        mode3   = 1'b0;
  logic        pin_hi  = 1'b1;
  int          err_total  = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  int          busy_run   = 0;
  int          busy_last  = 0;

  always #20 ref_clk = ~ref_clk;

  snf_link_if snf_link_if_inst ();
  snf_host snf_host_inst (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .wb_cyc_i (cyc),
    .wb_stb_i (stb),
    .wb_we_i  (we),
    .wb_adr_i (adr),
    .wb_sel_i (4'hF),
    .wb_dat_i (wdat),
    .wb_dat_o (rdat),
    .wb_ack_o (ack),
    .link     (snf_link_if_inst.host)
  );
  snf_device #(.FIRST_RST_CYC(FIRST_N), .IDLE_RST_CYC(IDLE_N)) snf_device_inst (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .link         (snf_link_if_inst.device),
    .ecc_enable   (ecc),
    .otp_access   (otp),
    .quad_allowed (quad),
    .read_only    (ro),
    .region_lock  (region),
    .busy         (busy)
  );
  snf_link_props snf_link_props_inst (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cs_n    (snf_link_if_inst.cs_n),
    .sck     (snf_link_if_inst.sck),
    .mosi    (snf_link_if_inst.mosi),
    .miso    (snf_link_if_inst.miso),
    .miso_oe (snf_link_if_inst.miso_oe),
    .guard_n (snf_link_if_inst.guard_n)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // One link command, then poll host status until the frame is over
  task automatic feat(input logic [7:0] op, input logic [7:0] fa, input logic [7:0] d, output logic [7:0] v);
    logic [31:0] r;
    wb(1'b1, HOST_CMD_OFS, {5'h00, pin_hi, 1'b1, mode3, d, fa, op}, r);
    do begin
      wb(1'b0, HOST_STAT_OFS, 32'h0, r);
    end while (r[0] !== 1'b0);
    v = r[15:8];
  endtask

  task automatic wr(input logic [7:0] fa, input logic [7:0] d);
    logic [7:0] v;
    feat(OP_SET_FEATURE, fa, d, v);
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] v;
    feat(op, 8'h00, 8'h00, v);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] fa, input logic [7:0] e);
    logic [7:0] v;
    feat(OP_GET_FEATURE, fa, 8'h00, v);
    chk(nm, v, e);
  endtask

  // Extra edge lets the busy length tracker record the finished run
  task automatic settle();
    while (busy !== 1'b0) begin
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
  endtask

  task automatic pwr();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    mode3 = 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (busy === 1'b1)
      busy_run++;
    else if (busy_run != 0) begin
      busy_last = busy_run;
      busy_run  = 0;
    end
    if (cycles == 60000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk("lock", FA_LOCK, LOCK_RESET);
    rd_chk("config", FA_CONFIG, CONFIG_RESET);
    rd_chk("status", FA_STATUS, 8'h00);
    rd_chk("drive", FA_DRIVE, DRIVE_RESET);
    chk("region", region, 5'h1F);
    chk("ecc", ecc, 1'b1);
    $display("test power_on finished");
    for (int m = 0; m < 2; m++) begin
      mode3 = m[0];
      wr(FA_DRIVE, 8'hFF);
      rd_chk("drive", FA_DRIVE, DRIVE_MASK);
      wr(FA_CONFIG, 8'h4F);
      rd_chk("config", FA_CONFIG, 8'h40);
      chk("otp", otp, 1'b1);
      chk("ecc", ecc, 1'b0);
      cmd(OP_WRITE_ENABLE);
      rd_chk("latch", FA_STATUS, 8'h02);
      cmd(OP_WRITE_DISABLE);
      rd_chk("latch", FA_STATUS, 8'h00);
      wr(FA_CONFIG, CONFIG_RESET);
    end
    mode3 = 1'b0;
    $display("test modes finished");
    wr(FA_LOCK, 8'h00);
    rd_chk("lock", FA_LOCK, 8'h00);
    chk("quad", quad, 1'b1);
    chk("region", region, 5'h00);
    wr(FA_LOCK, 8'h80);
    pin_hi = 1'b0;
    wr(FA_LOCK, 8'h88);
    rd_chk("lock", FA_LOCK, 8'h80);
    pin_hi = 1'b1;
    wr(FA_LOCK, 8'h88);
    rd_chk("lock", FA_LOCK, 8'h88);
    wr(FA_LOCK, 8'h02);
    rd_chk("lock", FA_LOCK, 8'h02);
    chk("quad", quad, 1'b0);
    pin_hi = 1'b0;
    wr(FA_LOCK, 8'h00);
    wr(FA_DRIVE, 8'h20);
    rd_chk("lock", FA_LOCK, 8'h02);
    rd_chk("drive", FA_DRIVE, DRIVE_MASK);
    chk("ro", ro, 1'b1);
    pin_hi = 1'b1;
    wr(FA_LOCK, 8'h81);
    rd_chk("lock", FA_LOCK, 8'h81);
    chk("ro", ro, 1'b0);
    wr(FA_CONFIG, 8'h30);
    wr(FA_LOCK, 8'h00);
    wr(FA_CONFIG, 8'h10);
    rd_chk("lock", FA_LOCK, 8'h81);
    rd_chk("config", FA_CONFIG, 8'h30);
    $display("test guards finished");
    cmd(OP_RESET);
    rd_chk("status", FA_STATUS, 8'h01);
    wr(FA_DRIVE, 8'h00);
    settle();
    chk("first_busy", busy_last inside {[FIRST_N - 2:FIRST_N + 2]}, 1'b1);
    rd_chk("drive", FA_DRIVE, DRIVE_MASK);
    rd_chk("lock", FA_LOCK, 8'h81);
    cmd(OP_RESET);
    settle();
    chk("idle_busy", busy_last inside {[IDLE_N - 2:IDLE_N + 2]}, 1'b1);
    $display("test reset_command finished");
    pwr();
    rd_chk("lock", FA_LOCK, LOCK_RESET);
    rd_chk("config", FA_CONFIG, CONFIG_RESET);
    wr(FA_LOCK, 8'h01);
    wr(FA_LOCK, 8'h00);
    rd_chk("lock", FA_LOCK, 8'h01);
    pwr();
    rd_chk("lock", FA_LOCK, LOCK_RESET);
    $display("test power_cycle finished");
    print_verdict();
  end
endmodule
